// ==== design/sbtc_cfg.svh ====
// Constants for the sixteen-bit timer/counter: register offsets, bit positions,
// reset values and timing counts. Definitions only; included by bare name.
`ifndef SBTC_CFG_SVH
`define SBTC_CFG_SVH

// Register bus geometry.
`define SBTC_AW            3
`define SBTC_DW            8

// Register offsets on the plain register port.
`define SBTC_OFF_CTRL      3'h0
`define SBTC_OFF_CNT_LO    3'h1
`define SBTC_OFF_CNT_HI    3'h2
`define SBTC_OFF_PREQ      3'h3
`define SBTC_OFF_PEN       3'h4
`define SBTC_OFF_INTCTL    3'h5
`define SBTC_OFF_PINS      3'h6

// Bit positions.
`define SBTC_PREQ_OVF      0
`define SBTC_PEN_OVF       0
`define SBTC_INTCTL_GIE    7
`define SBTC_INTCTL_PERIPH_IRQ_ENABLE   6
`define SBTC_PINS_VAL_A    0
`define SBTC_PINS_VAL_B    1
`define SBTC_PINS_DIR_A    2
`define SBTC_PINS_DIR_B    3
`define SBTC_CTRL_ON       0

// Reset values and masks.
`define SBTC_CTRL_RST      8'h00
`define SBTC_CTRL_MASK     8'h3f
`define SBTC_INTCTL_RST    8'h00
`define SBTC_DIR_RST       2'h3
`define SBTC_DIR_IN        2'h3
`define SBTC_CNT_RST       16'h0000
`define SBTC_CNT_MAX       16'hffff
`define SBTC_CNT_ONE       16'h0001

// Reference clock cycles per instruction cycle (oscillator frequency / 4).
`define SBTC_INSTR_DIV     4

`endif

// ==== design/sbtc_pkg.sv ====
// Types shared by the timer/counter files.
// Assumes the constants of sbtc_cfg.svh; holds no logic of its own.
package sbtc_pkg;

    // Timer control register layout.
    typedef struct packed {
        logic [1:0] rsvd;
        logic [1:0] prescale_select;
        logic       crystal_osc_enable;
        logic       sync_bypass;
        logic       clock_source_select;
        logic       timer_on;
    } sbtc_ctrl_t;

    // Prescale terminal count: ratio minus one for each select code.
    function automatic logic [2:0] sbtc_ratio_mask(input logic [1:0] sel);
        logic [2:0] m;
        m = 3'h0;
        case (sel)
            2'h0:    m = 3'h0;
            2'h1:    m = 3'h1;
            2'h2:    m = 3'h3;
            default: m = 3'h7;
        endcase
        return m;
    endfunction

endpackage

// ==== design/sbtc_prescaler.sv ====
// Hidden prescale counter: passes one of every 1, 2, 4 or 8 input ticks.
// Assumes tick and clear come from logic on ref_clk.
`timescale 1ns/1ps
module sbtc_prescaler (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Control.
    input  wire logic       clear,
    input  wire logic [1:0] sel,
    // Ticks.
    input  wire logic       tick_in,
    output logic            tick_out
);

    logic [2:0] cnt_r;
    logic [2:0] mask;

    assign mask     = sbtc_pkg::sbtc_ratio_mask(sel);
    assign tick_out = tick_in && !clear && ((cnt_r & mask) == mask);

    // Clearing wins over a tick so the count restarts cleanly after a write.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 3'h0;
        end else if (clear) begin
            cnt_r <= 3'h0;
        end else if (tick_in) begin
            cnt_r <= tick_out ? 3'h0 : cnt_r + 3'h1;
        end
    end

    // Helper: input ticks since the last output tick, kept apart from cnt_r
    // so the ratio check does not lean on the mask logic it guards.
    logic [3:0] chk_ticks_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_ticks_r <= 4'h0;
        end else if (clear || tick_out) begin
            chk_ticks_r <= 4'h0;
        end else if (tick_in) begin
            chk_ticks_r <= chk_ticks_r + 4'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_prescale_ratio: assert property (
        tick_out |-> chk_ticks_r == (4'h1 << sel) - 4'h1)
        else $error("prescaler ratio wrong");
    a_write_clears_pre: assert property (
        clear && sel != 2'h0 ##1 sel != 2'h0 |-> !tick_out)
        else $error("prescaler not cleared by count write");

endmodule

// ==== design/sbtc_sync.sv ====
// Two-stage synchroniser for a group of level inputs from pins.
// Assumes each bit is independent; no word coherence is promised.
`timescale 1ns/1ps
module sbtc_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // Levels.
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] d_out
);

    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            d_out  <= '0;
        end else begin
            meta_r <= d_in;
            d_out  <= meta_r;
        end
    end

endmodule

// ==== design/sbtc_timer.sv ====
// Sixteen-bit timer/counter with prescaler, sync and async counting,
// crystal option and gated overflow interrupt.
// Assumes ref_clk is the oscillator clock and the register master is on ref_clk.
//
// Contract
// - Sixteen-bit up-counter in two byte registers; byte writes replace live count.
// - Source select 0 counts oscillator/4, 1 counts the external input.
// - Internal source advances once per instruction cycle times prescale ratio.
// - External source advances on each rising edge, after prescaling.
// - After reset, count write or high-then-low re-enable, a falling edge must come first.
// - Four prescale ratios 1, 2, 4, 8 chosen by a two-bit field.
// - Prescale codes 00, 01, 10, 11 give 1:1, 1:2, 1:4, 1:8.
// - Prescale counter is hidden and cleared by any count byte write.
// - Oscillator enable bit turns on the crystal oscillator, kept on in sleep.
// - With the crystal on, shared pins are inputs: values read 0, directions 1.
// - Sync bypass counts the external clock without instruction-phase alignment.
// - Async counting continues in sleep and overflow wakes the processor.
// - Mode switches may drop or add one increment.
// - No capture/compare time base while counting asynchronously.
// - Count byte reads return valid values in async counting.
// - Rollover from ffff to 0000 sets the overflow flag.
// - Interrupt goes out only with local, peripheral and global enables set.
// - The flag stays set until software clears it.
// - Counting happens only while timer on is set, in sleep too.
`timescale 1ns/1ps
`include "sbtc_cfg.svh"
module sbtc_timer #(
    parameter int INSTR_DIV = `SBTC_INSTR_DIV
) (
    // Clock and reset.
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // Register port.
    input  wire logic [`SBTC_AW-1:0] reg_addr,
    input  wire logic [`SBTC_DW-1:0] reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [`SBTC_DW-1:0] reg_rdata,
    // Processor state.
    input  wire logic                sleep_mode,
    output logic                     irq,
    output logic                     wake,
    // Pins.
    input  wire logic                ext_count_input,
    input  wire logic                crystal_in_pin,
    input  wire logic                shared_pin_a_value,
    input  wire logic                shared_pin_b_value,
    output logic                     crystal_osc_enable,
    output logic      [1:0]          shared_pin_direction,
    // Time base to the capture/compare unit.
    output logic      [15:0]         count_value,
    output logic                     timebase_valid
);

    if (INSTR_DIV < 1 || INSTR_DIV > 16) begin : g_bad_div
        $error("INSTR_DIV must lie between 1 and 16");
    end

    sbtc_pkg::sbtc_ctrl_t ctrl_r;
    logic [15:0]          cnt_r;
    logic [7:0]           intctl_r;
    logic                 flag_r;
    logic                 ie_r;
    logic [1:0]           dir_r;
    logic [3:0]           div_r;
    logic                 need_fall_r;
    logic                 hold_hi_r;
    logic                 pending_r;
    logic                 ext_d_r;
    logic [3:0]           pin_s;
    logic                 ext_s;
    logic                 ext_rise;
    logic                 ext_fall;
    logic                 instr_tick;
    logic                 pre_tick;
    logic                 pre_out;
    logic                 is_async;
    logic                 inc;
    logic                 ovf_evt;
    logic                 wr_lo;
    logic                 wr_hi;
    logic                 cnt_wr;
    logic                 ctrl_wr;
    logic                 preq_wr;
    logic [`SBTC_DW-1:0]  rd_nxt;

    // Pin levels pass two flip-flops before any logic reads them.
    sbtc_sync #(
        .W (4)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d_in    ({shared_pin_b_value, shared_pin_a_value,
                   crystal_in_pin, ext_count_input}),
        .d_out   (pin_s)
    );

    // Count input is the crystal output when the oscillator runs.
    assign ext_s    = ctrl_r.crystal_osc_enable ? pin_s[1] : pin_s[0];
    assign ext_rise = ext_s && !ext_d_r;
    assign ext_fall = !ext_s && ext_d_r;
    assign is_async = ctrl_r.clock_source_select && ctrl_r.sync_bypass;

    // Register strobes.
    assign wr_lo   = reg_wr && (reg_addr == `SBTC_OFF_CNT_LO);
    assign wr_hi   = reg_wr && (reg_addr == `SBTC_OFF_CNT_HI);
    assign cnt_wr  = wr_lo || wr_hi;
    assign ctrl_wr = reg_wr && (reg_addr == `SBTC_OFF_CTRL);
    assign preq_wr = reg_wr && (reg_addr == `SBTC_OFF_PREQ);

    // Instruction cycle: one tick per INSTR_DIV clocks, stopped during sleep.
    assign instr_tick = (div_r == 4'(INSTR_DIV - 1)) && !sleep_mode;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 4'h0;
        end else if (div_r == 4'(INSTR_DIV - 1)) begin
            div_r <= 4'h0;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    // Edge history for the selected external input.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_d_r <= 1'b0;
        end else begin
            ext_d_r <= ext_s;
        end
    end

    // Tick into the prescaler: instruction cycles or armed rising edges.
    always_comb begin
        pre_tick = 1'b0;
        if (ctrl_r.timer_on) begin
            if (ctrl_r.clock_source_select) begin
                pre_tick = ext_rise && !need_fall_r;
            end else begin
                pre_tick = instr_tick;
            end
        end
    end

    // The prescale count is never visible on the register port.
    sbtc_prescaler u_presc (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clear    (cnt_wr),
        .sel      (ctrl_r.prescale_select),
        .tick_in  (pre_tick),
        .tick_out (pre_out)
    );

    // Synchronous external counting lands on the next instruction tick;
    // bypass applies it at once, so it still counts while sleeping.
    always_comb begin
        inc = 1'b0;
        if (ctrl_r.timer_on) begin
            if (!ctrl_r.clock_source_select || is_async) begin
                inc = pre_out;
            end else begin
                inc = instr_tick && (pending_r || pre_out);
            end
        end
    end

    // A pending sync increment is dropped on a mode change, which can
    // lose one count; this is the accepted cost of a simple handover.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_r <= 1'b0;
        end else if (cnt_wr || is_async || !ctrl_r.clock_source_select) begin
            pending_r <= 1'b0;
        end else if (pre_out && !instr_tick) begin
            pending_r <= 1'b1;
        end else if (instr_tick) begin
            pending_r <= 1'b0;
        end
    end

    // Arm for a falling edge; rising edges are ignored until one is seen.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            need_fall_r <= 1'b1;
        end else if (cnt_wr) begin
            need_fall_r <= 1'b1;
        end else if (ctrl_wr && !ctrl_r.timer_on && reg_wdata[`SBTC_CTRL_ON]
                     && hold_hi_r && !ext_s) begin
            need_fall_r <= 1'b1;
        end else if (ext_fall) begin
            need_fall_r <= 1'b0;
        end
    end

    // Input level captured when the timer is switched off.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_hi_r <= 1'b0;
        end else if (ctrl_wr && ctrl_r.timer_on && !reg_wdata[`SBTC_CTRL_ON]) begin
            hold_hi_r <= ext_s;
        end
    end

    // Control register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `SBTC_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_r <= reg_wdata & `SBTC_CTRL_MASK;
        end
    end

    // Counter: a byte write wins over a coincident increment.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= `SBTC_CNT_RST;
        end else if (wr_lo) begin
            cnt_r[7:0] <= reg_wdata;
        end else if (wr_hi) begin
            cnt_r[15:8] <= reg_wdata;
        end else if (inc) begin
            cnt_r <= cnt_r + `SBTC_CNT_ONE;
        end
    end

    assign ovf_evt = inc && !cnt_wr && (cnt_r == `SBTC_CNT_MAX);

    // Overflow flag: a new rollover wins over a software clear.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (ovf_evt) begin
            flag_r <= 1'b1;
        end else if (preq_wr) begin
            flag_r <= reg_wdata[`SBTC_PREQ_OVF];
        end
    end

    // Enable registers.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_r     <= 1'b0;
            intctl_r <= `SBTC_INTCTL_RST;
        end else if (reg_wr && reg_addr == `SBTC_OFF_PEN) begin
            ie_r <= reg_wdata[`SBTC_PEN_OVF];
        end else if (reg_wr && reg_addr == `SBTC_OFF_INTCTL) begin
            intctl_r <= reg_wdata;
        end
    end

    // Shared pin directions are held at input while the crystal runs.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_r <= `SBTC_DIR_RST;
        end else if (ctrl_r.crystal_osc_enable) begin
            dir_r <= `SBTC_DIR_IN;
        end else if (reg_wr && reg_addr == `SBTC_OFF_PINS) begin
            dir_r <= {reg_wdata[`SBTC_PINS_DIR_B], reg_wdata[`SBTC_PINS_DIR_A]};
        end
    end

    // Read multiplexer; unmapped offsets read zero.
    always_comb begin
        rd_nxt = '0;
        case (reg_addr)
            `SBTC_OFF_CTRL:   rd_nxt = ctrl_r;
            `SBTC_OFF_CNT_LO: rd_nxt = cnt_r[7:0];
            `SBTC_OFF_CNT_HI: rd_nxt = cnt_r[15:8];
            `SBTC_OFF_PREQ:   rd_nxt[`SBTC_PREQ_OVF] = flag_r;
            `SBTC_OFF_PEN:    rd_nxt[`SBTC_PEN_OVF] = ie_r;
            `SBTC_OFF_INTCTL: rd_nxt = intctl_r;
            `SBTC_OFF_PINS: begin
                rd_nxt[`SBTC_PINS_DIR_A] = dir_r[0];
                rd_nxt[`SBTC_PINS_DIR_B] = dir_r[1];
                if (!ctrl_r.crystal_osc_enable) begin
                    rd_nxt[`SBTC_PINS_VAL_A] = pin_s[2];
                    rd_nxt[`SBTC_PINS_VAL_B] = pin_s[3];
                end
            end
            default:          rd_nxt = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rd_nxt;
        end else begin
            reg_rdata <= '0;
        end
    end

    // Interrupt and wake outputs. Wake needs no global enable, so a sleeping
    // processor resumes even with interrupts masked globally.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq  <= flag_r && ie_r && intctl_r[`SBTC_INTCTL_PERIPH_IRQ_ENABLE]
                    && intctl_r[`SBTC_INTCTL_GIE];
            wake <= sleep_mode && flag_r && ie_r
                    && intctl_r[`SBTC_INTCTL_PERIPH_IRQ_ENABLE];
        end
    end

    // Pin and time-base outputs, all registered.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crystal_osc_enable   <= 1'b0;
            shared_pin_direction <= `SBTC_DIR_RST;
            count_value          <= `SBTC_CNT_RST;
            timebase_valid       <= 1'b0;
        end else begin
            crystal_osc_enable   <= ctrl_r.crystal_osc_enable;
            shared_pin_direction <= dir_r;
            count_value          <= cnt_r;
            timebase_valid       <= !is_async;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_low_byte_write: assert property (
        wr_lo |=> cnt_r[7:0] == $past(reg_wdata))
        else $error("low byte write did not land");
    a_off_holds_count: assert property (
        !ctrl_r.timer_on && !cnt_wr |=> $stable(cnt_r))
        else $error("count moved while timer off");
    a_internal_step: assert property (
        ctrl_r.timer_on && !ctrl_r.clock_source_select && !cnt_wr && pre_out
        |=> cnt_r == $past(cnt_r) + 16'h1)
        else $error("internal tick did not advance count");
    a_fall_before_rise: assert property (
        need_fall_r && ext_rise |-> !pre_tick)
        else $error("rising edge counted without prior fall");
    a_rollover_flag: assert property (
        inc && !cnt_wr && cnt_r == 16'hffff |=> flag_r && cnt_r == 16'h0)
        else $error("rollover did not set flag");
    a_flag_sticky: assert property (
        flag_r && !preq_wr |=> flag_r)
        else $error("flag dropped without clear");
    a_irq_gating: assert property (
        irq |-> $past(flag_r && ie_r && intctl_r[7] && intctl_r[6]))
        else $error("interrupt without all enables");
    a_crystal_inputs: assert property (
        ctrl_r.crystal_osc_enable |=> dir_r == 2'h3 ##1 shared_pin_direction == 2'h3)
        else $error("shared pins not forced to input");
    a_async_sleep_count: assert property (
        sleep_mode && is_async && ctrl_r.timer_on && pre_out && !cnt_wr
        |=> cnt_r == $past(cnt_r) + 16'h1)
        else $error("async count stalled in sleep");
    a_sync_sleep_frozen: assert property (
        sleep_mode && !is_async && !cnt_wr |=> $stable(cnt_r))
        else $error("synchronous count moved in sleep");

    c_rollover:   cover property (ovf_evt);
    c_wake:       cover property (sleep_mode && wake);
    c_async_inc:  cover property (is_async && inc);
    c_fall_armed: cover property (need_fall_r && ext_fall);

endmodule

// ==== dv/sbtc_ext_src.sv ====
// Model of the external count pin or crystal that feeds the timer.
// Assumes start is a one-cycle pulse on ref_clk, given by the bench.
`timescale 1ns/1ps
module sbtc_ext_src (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Command.
    input  wire logic       start,
    input  wire logic [7:0] n_pulses,
    // Pin.
    output logic            pin,
    output logic            busy
);
    logic [7:0] left_r;
    logic [2:0] ph_r;

    // Each pulse is four clocks low, then four high. That is wider than the
    // two clocks the synchroniser needs, and the pin rests low between bursts.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            left_r <= 8'h00;
            ph_r   <= 3'h0;
            pin    <= 1'b0;
        end else if (start) begin
            left_r <= n_pulses;
            ph_r   <= 3'h0;
        end else if (left_r != 8'h00) begin
            ph_r <= ph_r + 3'h1;
            if (ph_r == 3'h3) begin
                pin <= 1'b1;
            end
            if (ph_r == 3'h7) begin
                pin    <= 1'b0;
                left_r <= left_r - 8'h01;
            end
        end
    end

    // The bench waits on this flag until the burst is over.
    assign busy = (left_r != 8'h00);
endmodule

// ==== dv/test_sbtc_timer.sv ====
// Self-checking bench for the timer/counter.
// Assumes the design files and the pin model are compiled first.
`timescale 1ns/1ps
`include "sbtc_cfg.svh"
module test_sbtc_timer;
    logic        ref_clk    = 1'b0;
    logic        rst_n      = 1'b0;
    logic [2:0]  reg_addr   = 3'h0;
    logic [7:0]  reg_wdata  = 8'h00;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic        sleep_mode = 1'b0;
    logic        pin_a      = 1'b0;
    logic        pin_b      = 1'b0;
    logic        start      = 1'b0;
    logic [7:0]  n_pulses   = 8'h00;
    logic [7:0]  reg_rdata;
    logic        irq;
    logic        wake;
    logic        pin;
    logic        busy;
    logic        osc_en;
    logic [1:0]  dir;
    logic [15:0] count_value;
    logic        tb_valid;
    logic [7:0]  v;
    logic [15:0] c;
    logic [15:0] c2;
    int          err_total  = 0;
    int          cmp_count  = 0;
    int          cycles     = 0;

    sbtc_timer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_mode(sleep_mode), .irq(irq), .wake(wake), .ext_count_input(pin),
        .crystal_in_pin(pin), .shared_pin_a_value(pin_a), .shared_pin_b_value(pin_b),
        .crystal_osc_enable(osc_en), .shared_pin_direction(dir),
        .count_value(count_value), .timebase_valid(tb_valid));
    sbtc_ext_src ext_u (.ref_clk(ref_clk), .rst_n(rst_n), .start(start),
        .n_pulses(n_pulses), .pin(pin), .busy(busy));

    // Clock at 50 MHz.
    always #10 ref_clk = ~ref_clk;

    // A hang is cut off after far more cycles than the whole run needs.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Allows one count of slack, because the tick phase at enable is free.
    task automatic near(input logic [15:0] g, input logic [15:0] e);
        cmp_count = cmp_count + 1;
        if (!(g === e || g === e + 16'h1 || g + 16'h1 === e)) begin
            err_total = err_total + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rd_cnt(output logic [15:0] q);
        rd(`SBTC_OFF_CNT_LO, q[7:0]);
        rd(`SBTC_OFF_CNT_HI, q[15:8]);
    endtask

    task automatic clr_cnt();
        wr(`SBTC_OFF_CNT_LO, 8'h00);
        wr(`SBTC_OFF_CNT_HI, 8'h00);
    endtask

    // Asks the pin model for a burst and waits for the synchroniser to settle.
    task automatic pulses(input logic [7:0] n);
        @(posedge ref_clk);
        start    <= 1'b1;
        n_pulses <= n;
        @(posedge ref_clk);
        start <= 1'b0;
        @(posedge ref_clk); // The model took the burst on the edge before; busy shows from here.
        while (busy === 1'b1) @(posedge ref_clk);
        repeat (12) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        rd(`SBTC_OFF_CTRL, v);
        chk(16'(v), 16'h0000);
        rd(`SBTC_OFF_PINS, v);
        chk(16'(v), 16'h000c);
        rd(3'h7, v);
        chk(16'(v), 16'h0000);
        chk(count_value, 16'h0000);
    endtask

    task automatic t_bytes();
        wr(`SBTC_OFF_CNT_LO, 8'h34);
        wr(`SBTC_OFF_CNT_HI, 8'h12);
        rd_cnt(c);
        chk(c, 16'h1234);
        chk(count_value, 16'h1234);
        chk(16'(tb_valid), 16'h0001);
    endtask

    // Every prescale code over the same span; the timer is stopped before
    // each count write, so no write races an increment.
    task automatic t_rates();
        for (int s = 0; s < 4; s++) begin
            clr_cnt();
            wr(`SBTC_OFF_CTRL, {2'b00, 2'(s), 4'h1});
            repeat (320) @(posedge ref_clk);
            wr(`SBTC_OFF_CTRL, 8'h00);
            rd_cnt(c);
            near(c, 16'd80 >> s);
        end
        repeat (40) @(posedge ref_clk);
        rd_cnt(c2);
        chk(c2, c);
    endtask

    task automatic t_ovf();
        wr(`SBTC_OFF_CNT_LO, 8'hfe);
        wr(`SBTC_OFF_CNT_HI, 8'hff);
        wr(`SBTC_OFF_CTRL, 8'h01);
        repeat (20) @(posedge ref_clk);
        wr(`SBTC_OFF_CTRL, 8'h00);
        rd(`SBTC_OFF_PREQ, v);
        chk(16'(v[0]), 16'h0001);
        chk(16'(irq), 16'h0000);
        wr(`SBTC_OFF_PEN, 8'h01);
        wr(`SBTC_OFF_INTCTL, 8'h40);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(16'(irq), 16'h0000);
        chk(16'(wake), 16'h0001);
        wr(`SBTC_OFF_INTCTL, 8'hc0);
        repeat (3) @(posedge ref_clk);
        chk(16'(irq), 16'h0001);
        rd(`SBTC_OFF_PREQ, v);
        chk(16'(v[0]), 16'h0001);
        wr(`SBTC_OFF_PREQ, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk(16'(irq), 16'h0000);
        chk(16'(wake), 16'h0000);
        wr(`SBTC_OFF_INTCTL, 8'h00);
        sleep_mode <= 1'b0;
    endtask

    // The count write arms the falling-edge guard, so the first rise is lost.
    task automatic t_ext();
        clr_cnt();
        wr(`SBTC_OFF_CTRL, 8'h03);
        pulses(8'd5);
        rd_cnt(c);
        chk(c, 16'h0004);
        chk(16'(tb_valid), 16'h0001);
        sleep_mode <= 1'b1;
        wr(`SBTC_OFF_CTRL, 8'h07);
        pulses(8'd3);
        rd_cnt(c);
        chk(c, 16'h0007);
        chk(16'(tb_valid), 16'h0000);
        wr(`SBTC_OFF_CTRL, 8'h00);
        sleep_mode <= 1'b0;
    endtask

    task automatic t_xtal();
        pin_a <= 1'b1;
        pin_b <= 1'b1;
        wr(`SBTC_OFF_PINS, 8'h00);
        repeat (4) @(posedge ref_clk);
        rd(`SBTC_OFF_PINS, v);
        chk(16'(v), 16'h0003);
        chk(16'(dir), 16'h0000);
        wr(`SBTC_OFF_CTRL, 8'h08);
        repeat (50) @(posedge ref_clk);
        chk(16'(osc_en), 16'h0001);
        chk(16'(dir), 16'h0003);
        rd(`SBTC_OFF_PINS, v);
        chk(16'(v), 16'h000c);
        clr_cnt();
        wr(`SBTC_OFF_CTRL, 8'h0b);
        pulses(8'd3);
        rd_cnt(c);
        chk(c, 16'h0002);
        wr(`SBTC_OFF_CTRL, 8'h00);
    endtask

    // Reset for two cycles, then every scenario in turn.
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_bytes();
        t_rates();
        t_ovf();
        t_ext();
        t_xtal();
        end_of_test();
    end
endmodule
